//--- nfd_addr_seq.sv
`timescale 1ns/1ps
`default_nettype none

module nfd_addr_seq import nfd_pkg::*; (
    input wire logic clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] address,
    input wire logic strobeN,
    input wire logic chipSelN,
    input wire logic outputEnableN,
    input wire logic gridPackage,
    input wire nfd_die_view_t dieView [DIES],
    output logic [ADDR_W-1:0] accWord,
    output logic accDie,
    output logic [ADDR_W-1:0] wrWord,
    output logic wrDie,
    output logic waitNow
);

    logic [ADDR_W-1:0] latchedAddr;
    logic [ADDR_W-1:0] burstAddr;
    logic [CFG_LAT_W-1:0] latCnt;
    logic captured;
    logic burstOn;
    logic [ADDR_W-1:0] asyncAddr;
    logic [ADDR_W-1:0] accRaw;
    logic captureNow;

    function automatic logic dieOf(input logic [ADDR_W-1:0] a, input logic grid);
        return grid ? a[GRID_DIE_BIT] : a[STACK_DIE_BIT]; // R17 R18
    endfunction

    function automatic logic [ADDR_W-1:0] wordOf(input logic [ADDR_W-1:0] a, input logic grid);
        return grid ? {1'b0, a[ADDR_W-1:1]} : a;
    endfunction

    // ==================================================
    // address latch: flows while strobe low, holds after it rises
    assign asyncAddr = strobeN ? latchedAddr : address; // R21

    always_ff @(posedge clk) begin
        if (rst) begin
            latchedAddr <= '0;
        end else if (!strobeN) begin
            latchedAddr <= address; // R21
        end
    end

    // ==================================================
    // burst sequencer
    // first clock with strobe low takes the address; later clocks with strobe still low add nothing
    assign captureNow = !chipSelN && !strobeN && !captured && dieView[dieOf(address, gridPackage)].syncMode; // R20

    always_ff @(posedge clk) begin
        if (rst) begin
            captured <= 1'b0;
        end else begin
            captured <= !strobeN && (captured || captureNow);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            burstOn <= 1'b0;
            burstAddr <= '0;
            latCnt <= '0;
        end else if (chipSelN) begin
            burstOn <= 1'b0;
        end else if (captureNow) begin
            burstOn <= 1'b1;
            burstAddr <= address; // R20
            latCnt <= dieView[dieOf(address, gridPackage)].latency;
        end else if (burstOn && !outputEnableN) begin
            if (latCnt != '0) begin
                latCnt <= latCnt - 1'b1;
            end else begin
                burstAddr <= burstAddr + (gridPackage ? 26'h0000002 : 26'h0000001); // R3
            end
        end
    end

    assign accRaw = burstOn ? burstAddr : asyncAddr;
    assign accDie = dieOf(accRaw, gridPackage);
    assign accWord = wordOf(accRaw, gridPackage);
    assign wrDie = dieOf(asyncAddr, gridPackage);
    assign wrWord = wordOf(asyncAddr, gridPackage);
    assign waitNow = burstOn && (latCnt != '0); // R3

endmodule

`default_nettype wire

//--- nfd_flash_top.sv
// How it works
// R1: after reset reads come from the array in asynchronous mode
// R2: burst mode only once software clears the async bit in configuration
// R3: burst data steps with the clock; wait marks data not yet valid
// R4: program and erase are timed internally once started
// R5: status word shows ready plus program, erase, supply and lock errors
// R6: automation starts only on a complete correct command sequence
// R7: an erase clears only the addressed block
// R8: during erase suspend other blocks may be read and programmed
// R9: during program suspend other locations may be read
// R10: programming always writes a whole 16-bit word
// R11: the data path is 16 bits wide
// R12: supply below lockout refuses every program and erase; a suspended one still resumes on CMD_CONFIRM without a supply check
// R13: lock and unlock apply on the very command that sets them
// R14: password guards chosen blocks against writes, reads, or both
// R15: select active with top address bit low routes to the lower die
// R16: select active with top address bit high routes to the upper die
// R17: stacked variant selects the die with address bit 24
// R18: grid variant selects the die with address bit 25
// R19: select inactive floats data and wait
// R20: burst address taken on first clock with strobe low
// R21: async address flows while strobe low, holds once it rises
// R22: the unselected die ignores all cycles and keeps outputs floating
// R23: each die keeps its own mode, status and locks
`timescale 1ns/1ps
`default_nettype none

module nfd_flash_top import nfd_pkg::*; #(
    parameter int BLOCKS = 4,
    parameter int WORDS_PER_BLOCK = 4,
    parameter logic [DATA_W-1:0] PASSWORD_KEY = 16'h5A3C // arbitrary value
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic diePairSelectN,
    input wire logic addressLatchStrobeN,
    input wire logic [ADDR_W-1:0] address,
    input wire logic writeEnableN,
    input wire logic outputEnableN,
    input wire logic [DATA_W-1:0] dataIn,
    input wire logic supplyAboveLockout,
    input wire logic gridPackage,
    output logic [DATA_W-1:0] dataOut,
    output logic dataOe,
    output logic waitOut,
    output logic waitOe
);

    localparam int WORDS = BLOCKS * WORDS_PER_BLOCK;
    localparam int WORD_IDX_W = $clog2(WORDS);
    localparam int OFS_W = $clog2(WORDS_PER_BLOCK);
    localparam int BLK_W = WORD_IDX_W - OFS_W;

    // ==================================================
    // write strobe and routing
    logic weQ;
    logic wrPulse;
    logic [ADDR_W-1:0] accWord;
    logic [ADDR_W-1:0] wrWord;
    logic accDie;
    logic wrDie;
    logic waitNow;
    nfd_bus_req_t wrReq;
    nfd_die_view_t dieView [DIES];
    logic [DATA_W-1:0] rdData [DIES];

    always_ff @(posedge clk) begin
        if (rst) begin
            weQ <= 1'b1;
        end else begin
            weQ <= writeEnableN;
        end
    end

    // a write is taken on the rising edge of the write strobe
    assign wrPulse = !diePairSelectN && !weQ && writeEnableN;
    assign wrReq = '{addr: wrWord, data: dataIn}; // R11

    nfd_addr_seq u_seq (
        .clk(clk),
        .rst(rst),
        .address(address),
        .strobeN(addressLatchStrobeN),
        .chipSelN(diePairSelectN),
        .outputEnableN(outputEnableN),
        .gridPackage(gridPackage),
        .dieView(dieView),
        .accWord(accWord),
        .accDie(accDie),
        .wrWord(wrWord),
        .wrDie(wrDie),
        .waitNow(waitNow)
    );

    // ==================================================
    // per-die command engine
    for (genvar d = 0; d < DIES; d++) begin : g_die
        nfd_die_state_t state;
        logic [DATA_W-1:0] mem [WORDS];
        logic [DATA_W-1:0] cfg;
        logic [BLOCKS-1:0] lockMask;
        logic [BLOCKS-1:0] writeProt;
        logic [BLOCKS-1:0] readProt;
        logic passOpen;
        logic readStatus;
        logic eraseErr;
        logic progErr;
        logic supplyErr;
        logic lockErr;
        logic [WORD_IDX_W-1:0] opWord;
        logic [DATA_W-1:0] opData;
        logic opErase;
        logic [TIMER_W-1:0] timer;
        logic [WORD_IDX_W-1:0] savedWord;
        logic [DATA_W-1:0] savedData;
        logic savedErase;
        logic [TIMER_W-1:0] savedTimer;
        logic nested;
        logic hit;
        logic [7:0] cmd;
        logic [WORD_IDX_W-1:0] reqWord;
        logic [BLK_W-1:0] reqBlk;
        logic blkGuarded;
        logic doneNow;
        logic refuseProg;
        logic refuseErase;
        logic badSeq;
        logic clrNow;
        logic [WORD_IDX_W-1:0] rdWord;
        logic [7:0] statusWord;

        // the other die sees no strobe at all
        assign hit = wrPulse && (wrDie == 1'(d)); // R22 R23 R15 R16
        assign cmd = wrReq.data[7:0];
        assign reqWord = wrReq.addr[WORD_IDX_W-1:0];
        assign reqBlk = reqWord[WORD_IDX_W-1:OFS_W];
        assign blkGuarded = lockMask[reqBlk] || (writeProt[reqBlk] && !passOpen); // R14
        assign doneNow = (state == DS_BUSY) && (timer == 12'h001);
        // nested program may not touch the block whose erase is parked
        assign refuseProg = hit && (state == DS_PROG_SETUP)
            && (!supplyAboveLockout || blkGuarded
                || (nested && reqBlk == savedWord[WORD_IDX_W-1:OFS_W])); // R12 R8
        assign refuseErase = hit && (state == DS_ERASE_SETUP) && (cmd == CMD_CONFIRM)
            && (!supplyAboveLockout || blkGuarded); // R12
        assign badSeq = hit && (state == DS_ERASE_SETUP) && (cmd != CMD_CONFIRM); // R6
        assign clrNow = hit && (state == DS_READY) && (cmd == CMD_CLEAR_STATUS);

        // ==================================================
        // sequencing
        always_ff @(posedge clk) begin
            if (rst) begin
                state <= DS_READY;
                timer <= '0;
                opWord <= '0;
                opData <= '0;
                opErase <= 1'b0;
                nested <= 1'b0;
            end else begin
                case (state)
                    DS_READY: begin
                        if (hit) begin
                            case (cmd)
                                CMD_PROGRAM: state <= DS_PROG_SETUP;
                                CMD_ERASE: state <= DS_ERASE_SETUP;
                                CMD_SETUP: state <= DS_CMD_SETUP;
                                CMD_PASSWORD: state <= DS_PASS_SETUP;
                                default: state <= DS_READY;
                            endcase
                        end
                    end
                    DS_PROG_SETUP: begin
                        if (hit) begin
                            if (refuseProg) begin
                                state <= nested ? DS_SUSPENDED : DS_READY;
                                nested <= 1'b0;
                            end else begin
                                opWord <= reqWord;
                                opData <= wrReq.data; // R10
                                opErase <= 1'b0;
                                timer <= TIMER_W'(PROGRAM_CYCLES); // R4
                                state <= DS_BUSY;
                            end
                        end
                    end
                    DS_ERASE_SETUP: begin
                        if (hit) begin
                            if (cmd == CMD_CONFIRM && !refuseErase) begin
                                opWord <= reqWord; // R7
                                opErase <= 1'b1;
                                timer <= TIMER_W'(ERASE_CYCLES); // R4
                                state <= DS_BUSY;
                            end else begin
                                state <= DS_READY; // R6
                            end
                        end
                    end
                    DS_BUSY: begin
                        if (doneNow) begin
                            state <= nested ? DS_SUSPENDED : DS_READY;
                            nested <= 1'b0;
                            timer <= '0;
                        end else if (hit && cmd == CMD_SUSPEND && !nested) begin
                            state <= DS_SUSPENDED; // R8 R9
                        end else begin
                            timer <= timer - 1'b1; // R4
                        end
                    end
                    DS_SUSPENDED: begin
                        if (hit && cmd == CMD_CONFIRM) begin
                            opWord <= savedWord;
                            opData <= savedData;
                            opErase <= savedErase;
                            timer <= savedTimer;
                            state <= DS_BUSY;
                        end else if (hit && cmd == CMD_PROGRAM && savedErase) begin
                            nested <= 1'b1; // R8
                            state <= DS_PROG_SETUP;
                        end
                    end
                    DS_CMD_SETUP: begin
                        if (hit) begin
                            state <= DS_READY;
                        end
                    end
                    DS_PASS_SETUP: begin
                        if (hit) begin
                            state <= DS_READY;
                        end
                    end
                    default: state <= DS_READY;
                endcase
            end
        end

        // parked operation, kept while a nested program runs
        always_ff @(posedge clk) begin
            if (rst) begin
                savedWord <= '0;
                savedData <= '0;
                savedErase <= 1'b0;
                savedTimer <= '0;
            end else if (state == DS_BUSY && hit && cmd == CMD_SUSPEND && !nested && !doneNow) begin
                savedWord <= opWord;
                savedData <= opData;
                savedErase <= opErase;
                savedTimer <= timer;
            end
        end

        // ==================================================
        // configuration, locks and password
        always_ff @(posedge clk) begin
            if (rst) begin
                cfg <= CFG_RESET; // R1
                lockMask <= '0;
                writeProt <= '0;
                readProt <= '0;
                passOpen <= 1'b0;
            end else if (hit && state == DS_CMD_SETUP) begin
                case (cmd)
                    CMD_LOCK: lockMask[reqBlk] <= 1'b1; // R13
                    CMD_CONFIRM: lockMask[reqBlk] <= 1'b0; // R13
                    CMD_CONFIG: cfg <= wrReq.addr[DATA_W-1:0]; // R2
                    CMD_PROTECT: begin
                        // only an opened password may rewrite the guard masks
                        if (passOpen) begin
                            writeProt <= wrReq.addr[BLOCKS-1:0]; // R14
                            readProt <= wrReq.addr[2*BLOCKS-1:BLOCKS]; // R14
                        end
                    end
                    default: cfg <= cfg;
                endcase
            end else if (hit && state == DS_PASS_SETUP) begin
                passOpen <= (wrReq.data == PASSWORD_KEY); // R14
            end
        end

        // ==================================================
        // status flags: a new error wins over a clear in the same cycle
        always_ff @(posedge clk) begin
            if (rst) begin
                eraseErr <= 1'b0;
                progErr <= 1'b0;
                supplyErr <= 1'b0;
                lockErr <= 1'b0;
            end else begin
                eraseErr <= (eraseErr && !clrNow) || refuseErase || badSeq; // R5
                progErr <= (progErr && !clrNow) || refuseProg || badSeq; // R5
                supplyErr <= (supplyErr && !clrNow)
                    || ((refuseProg || refuseErase) && !supplyAboveLockout); // R12
                lockErr <= (lockErr && !clrNow)
                    || ((refuseProg || refuseErase) && supplyAboveLockout && blkGuarded);
            end
        end

        always_ff @(posedge clk) begin
            if (rst) begin
                readStatus <= 1'b0; // R1
            end else if (hit) begin
                if (state == DS_READY || state == DS_SUSPENDED) begin
                    readStatus <= (cmd != CMD_READ_ARRAY);
                end else begin
                    readStatus <= 1'b1;
                end
            end
        end

        // ==================================================
        // array: whole words only; erase restricted to one block
        for (genvar w = 0; w < WORDS; w++) begin : g_word
            localparam logic [WORD_IDX_W-1:0] WI = WORD_IDX_W'(w);
            always_ff @(posedge clk) begin
                if (doneNow) begin
                    if (opErase && WI[WORD_IDX_W-1:OFS_W] == opWord[WORD_IDX_W-1:OFS_W]) begin
                        mem[w] <= ERASED_WORD; // R7
                    end else if (!opErase && WI == opWord) begin
                        mem[w] <= mem[w] & opData; // R10
                    end
                end
            end
        end

        // ==================================================
        // read view
        assign statusWord = {
            state != DS_BUSY,
            state == DS_SUSPENDED && savedErase,
            eraseErr,
            progErr,
            supplyErr,
            state == DS_SUSPENDED && !savedErase,
            lockErr,
            1'b0
        }; // R5
        assign rdWord = accWord[WORD_IDX_W-1:0];
        // reads of other locations proceed untouched while an operation is parked
        assign rdData[d] = readStatus ? {8'h00, statusWord}
            : (readProt[rdWord[WORD_IDX_W-1:OFS_W]] && !passOpen) ? BLOCKED_WORD
            : mem[rdWord]; // R9 R14
        assign dieView[d] = '{syncMode: !cfg[CFG_ASYNC_BIT],
            latency: cfg[CFG_LAT_LSB +: CFG_LAT_W]}; // R2
    end

    // ==================================================
    // pin drivers
    always_ff @(posedge clk) begin
        if (rst) begin
            dataOut <= '0;
            dataOe <= 1'b0;
            waitOut <= 1'b0;
            waitOe <= 1'b0;
        end else begin
            dataOut <= rdData[accDie]; // R15 R16 R17 R18
            dataOe <= !diePairSelectN && !outputEnableN && writeEnableN; // R19 R22
            waitOut <= waitNow; // R3
            waitOe <= !diePairSelectN && dieView[accDie].syncMode; // R19 R3
        end
    end

endmodule

`default_nettype wire

//--- nfd_flash_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// port checks
module nfd_flash_top_chk import nfd_pkg::*; (
    input wire logic clk,
    input wire logic rst,
    input wire logic diePairSelectN,
    input wire logic writeEnableN,
    input wire logic outputEnableN,
    input wire logic [DATA_W-1:0] dataIn,
    input wire logic [DATA_W-1:0] dataOut,
    input wire logic dataOe,
    input wire logic waitOe
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic cfgCmd;
    // any taken write of the config code counts, so burst can never be seen before one
    always_ff @(posedge clk) begin
        if (rst) begin
            cfgCmd <= 1'b0;
        end else if (!$past(writeEnableN) && writeEnableN && !diePairSelectN && dataIn[7:0] == CMD_CONFIG) begin
            cfgCmd <= 1'b1;
        end
    end
    sequence idle_s;
        diePairSelectN [*2];
    endsequence
    sequence read_s;
        !diePairSelectN && !outputEnableN && writeEnableN;
    endsequence
    reset_quiet_a: assert property (disable iff (1'b0) rst |=> dataOut == '0 && !dataOe && !waitOe) else $error("reset drive");
    desel_float_a: assert property (diePairSelectN |=> !dataOe && !waitOe) else $error("deselected drive");
    desel_hold_a: assert property (idle_s |-> !dataOe && !waitOe) else $error("idle drive");
    read_drive_a: assert property (read_s |=> dataOe) else $error("read not driven");
    drive_cause_a: assert property (dataOe |-> !$past(diePairSelectN)) else $error("drive without select");
    oe_off_a: assert property (outputEnableN |=> !dataOe) else $error("drive with enable high");
    wait_cause_a: assert property (waitOe |-> !$past(diePairSelectN)) else $error("wait without select");
    async_default_a: assert property (!cfgCmd |-> !waitOe) else $error("wait before config");
endmodule
bind nfd_flash_top nfd_flash_top_chk u_chk (.clk(clk), .rst(rst), .diePairSelectN(diePairSelectN),
    .writeEnableN(writeEnableN), .outputEnableN(outputEnableN), .dataIn(dataIn), .dataOut(dataOut),
    .dataOe(dataOe), .waitOe(waitOe));
`default_nettype wire

//--- nfd_flash_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// bench
module nfd_flash_top_tb import nfd_pkg::*;;
    localparam logic [ADDR_W-1:0] DIE1 = 26'h1000000;
    localparam logic [ADDR_W-1:0] GRID_DIE1 = 26'h2000000;
    // async bit clear, latency field 2: the first burst beat still waits
    localparam logic [ADDR_W-1:0] SYNC_CFG = 26'h0001000;
    logic clk = 1'b0, rst = 1'b1, supply = 1'b1, grid = 1'b0, expWait = 1'b0;
    logic selN, strbN, weN, oeN, dataOe, waitOut, waitOe, look;
    logic [ADDR_W-1:0] address;
    logic [DATA_W-1:0] dataIn, dataOut, v, d;
    logic [31:0] lfsrState = 32'h5964;
    logic [32:0] expQ [$];
    int failures = 0, compares = 0, cycles = 0;
    always #12.5 clk = ~clk;
    nfd_flash_top dut (.clk(clk), .rst(rst), .diePairSelectN(selN), .addressLatchStrobeN(strbN), .address(address),
        .writeEnableN(weN), .outputEnableN(oeN), .dataIn(dataIn), .supplyAboveLockout(supply), .gridPackage(grid),
        .dataOut(dataOut), .dataOe(dataOe), .waitOut(waitOut), .waitOe(waitOe));
    nfd_host_model host (.clk(clk), .dataOut(dataOut), .diePairSelectN(selN), .addressLatchStrobeN(strbN),
        .address(address), .writeEnableN(weN), .outputEnableN(oeN), .dataIn(dataIn), .look(look));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: read %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("compares %0d, failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic cmd(input logic [ADDR_W-1:0] a, input logic [7:0] c);
        host.wr(a, {8'h00, c});
    endtask
    task automatic note_rd(input logic [ADDR_W-1:0] a, input logic [15:0] m, input logic [15:0] e);
        expQ.push_back({expWait, m, e});
        host.rd(a, 1'b1, v);
    endtask
    // a hung engine runs the poll out and then fails the status compare
    task automatic wait_ready(input logic [ADDR_W-1:0] a);
        cmd(a, CMD_READ_STATUS);
        v = '0;
        for (int i = 0; i < 800 && v[ST_READY] !== 1'b1; i++) begin
            host.rd(a, 1'b0, v);
        end
    endtask
    always @(negedge clk) begin
        if (look === 1'b1) begin
            check(dataOut & expQ[0][31:16], expQ[0][15:0]);
            check(16'(waitOut), 16'(expQ[0][32]));
            void'(expQ.pop_front());
        end
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 12000) begin
            failures++;
            close_out();
        end
    end
    initial begin
        repeat (12) @(posedge clk);
        #1 rst = 1'b0;
        cmd('0, CMD_ERASE);
        cmd('0, CMD_CONFIRM);
        wait_ready('0);
        note_rd('0, 16'h00FF, 16'h0080);
        cmd('0, CMD_READ_ARRAY);
        for (int i = 0; i < 4; i++) begin
            note_rd(ADDR_W'(i), 16'hFFFF, ERASED_WORD);
        end
        $display("erase test done");
        d = '1;
        for (int i = 0; i < 2; i++) begin
            lfsrState = lfsr(lfsrState);
            d = d & lfsrState[15:0];
            cmd(26'h2, CMD_PROGRAM);
            host.wr(26'h2, lfsrState[15:0]);
            wait_ready(26'h2);
        end
        cmd('0, CMD_READ_ARRAY);
        note_rd(26'h2, 16'hFFFF, d);
        $display("program test done");
        supply = 1'b0;
        cmd(DIE1, CMD_PROGRAM);
        host.wr(DIE1, 16'h1234);
        cmd(DIE1, CMD_READ_STATUS);
        note_rd(DIE1, 16'h00FF, 16'h0098);
        cmd('0, CMD_READ_STATUS);
        note_rd('0, 16'h00FF, 16'h0080);
        supply = 1'b1;
        $display("lockout test done");
        cmd('0, CMD_ERASE);
        cmd('0, CMD_READ_ARRAY);
        cmd('0, CMD_READ_STATUS);
        note_rd('0, 16'h00FF, 16'h00B0);
        $display("sequence test done");
        cmd('0, CMD_CLEAR_STATUS);
        cmd('0, CMD_SETUP);
        cmd('0, CMD_LOCK);
        cmd('0, CMD_PROGRAM);
        host.wr('0, 16'h0000);
        note_rd('0, 16'h00FF, 16'h0092);
        $display("lock test done");
        grid = 1'b1;
        cmd(GRID_DIE1, CMD_READ_STATUS);
        note_rd(GRID_DIE1, 16'h00FF, 16'h0098);
        grid = 1'b0;
        $display("grid test done");
        cmd(SYNC_CFG, CMD_SETUP);
        cmd(SYNC_CFG, CMD_CONFIG);
        cmd('0, CMD_READ_ARRAY);
        expWait = 1'b1;
        note_rd(26'h1, 16'h0000, 16'h0000);
        $display("burst test done");
        close_out();
    end
endmodule
`default_nettype wire

//--- nfd_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// host bus master
module nfd_host_model import nfd_pkg::*; (
    input wire logic clk,
    input wire logic [DATA_W-1:0] dataOut,
    output logic diePairSelectN,
    output logic addressLatchStrobeN,
    output logic [ADDR_W-1:0] address,
    output logic writeEnableN,
    output logic outputEnableN,
    output logic [DATA_W-1:0] dataIn,
    output logic look
);
    initial begin
        {diePairSelectN, addressLatchStrobeN, writeEnableN, outputEnableN, look} = 5'b11110;
        address = '0;
        dataIn = '0;
    end
    // strobe low through each request so the address flows; raised after so the next burst captures afresh
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk) #1;
        {diePairSelectN, addressLatchStrobeN, writeEnableN} = 3'b000;
        address = a;
        dataIn = d;
        @(posedge clk) #1;
        writeEnableN = 1'b1;
        @(posedge clk) #1;
        diePairSelectN = 1'b1;
        addressLatchStrobeN = 1'b1;
        dataIn = ~d;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, input logic chk, output logic [DATA_W-1:0] v);
        @(posedge clk) #1;
        {diePairSelectN, addressLatchStrobeN, outputEnableN} = 3'b000;
        address = a;
        repeat (2) @(posedge clk);
        #1 look = chk;
        v = dataOut;
        @(posedge clk) #1;
        {diePairSelectN, addressLatchStrobeN, outputEnableN, look} = 4'hE;
    endtask
endmodule
`default_nettype wire

//--- nfd_pkg.sv
package nfd_pkg;

    // ==================================================
    // bus geometry and die select
    localparam int DATA_W = 16;
    localparam int ADDR_W = 26;
    localparam int DIES = 2;
    localparam int STACK_DIE_BIT = 24;
    localparam int GRID_DIE_BIT = 25;

    // ==================================================
    // command codes
    localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] CMD_PROGRAM = 8'h40;
    localparam logic [7:0] CMD_ERASE = 8'h20;
    localparam logic [7:0] CMD_CONFIRM = 8'hD0;
    localparam logic [7:0] CMD_SUSPEND = 8'hB0;
    localparam logic [7:0] CMD_SETUP = 8'h60;
    localparam logic [7:0] CMD_LOCK = 8'h01;
    localparam logic [7:0] CMD_CONFIG = 8'h03;
    localparam logic [7:0] CMD_PROTECT = 8'h02;
    localparam logic [7:0] CMD_PASSWORD = 8'h63;

    // ==================================================
    // status word bit positions
    localparam int ST_READY = 7;
    localparam int ST_ERASE_SUSP = 6;
    localparam int ST_ERASE_ERR = 5;
    localparam int ST_PROG_ERR = 4;
    localparam int ST_SUPPLY_ERR = 3;
    localparam int ST_PROG_SUSP = 2;
    localparam int ST_LOCK_ERR = 1;

    // ==================================================
    // read configuration
    localparam int CFG_ASYNC_BIT = 15;
    localparam int CFG_LAT_LSB = 11;
    localparam int CFG_LAT_W = 3;
    localparam logic [DATA_W-1:0] CFG_RESET = 16'hBFCF;

    // ==================================================
    // timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int PROGRAM_TIME_NS = 1000;
    localparam int ERASE_TIME_NS = 50000;
    localparam int PROGRAM_CYCLES = (PROGRAM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ERASE_CYCLES = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TIMER_W = 12;

    localparam logic [DATA_W-1:0] ERASED_WORD = 16'hFFFF;
    localparam logic [DATA_W-1:0] BLOCKED_WORD = 16'h0000;

    typedef enum logic [2:0] {
        DS_READY = 3'b000,
        DS_PROG_SETUP = 3'b001,
        DS_ERASE_SETUP = 3'b011,
        DS_BUSY = 3'b010,
        DS_SUSPENDED = 3'b110,
        DS_CMD_SETUP = 3'b111,
        DS_PASS_SETUP = 3'b101
    } nfd_die_state_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } nfd_bus_req_t;

    typedef struct packed {
        logic syncMode;
        logic [CFG_LAT_W-1:0] latency;
    } nfd_die_view_t;

endpackage
